// ==== common/pit_map.svh ====
// register offsets, control word fields and reset values of the interval timer
// assumes: included by the timer top only
// ==========================================================================
// What this block does
// - port select picks counter 0..2 or control
// - strobes ignored while device select is high
// - read strobe reads counters, write strobe writes
// - write to select 11 stores control word
// - control word is write-only; status via read-back
// - three identical independent channels, own modes
// - latched status holds control word, output, null
// - each channel counts with 16-bit presettable down counter
// - snapshot latch follows count, freezes until read
// - one snapshot byte at a time onto bus
// - reads return snapshot latch, never the counter
// - count bytes go to holding register, loaded later
// - both holding bytes load the counter together
// - control word write clears both holding bytes
// - counting element is never written directly
// - clock, gate and output pass channel control logic
// - data buffer drives only during selected reads
// - two-bit field in control word picks channel
// - new count leaves programmed mode unchanged
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH

// ==========================================================================
// port map
`define PIT_SEL_CH0 2'h0
`define PIT_SEL_CH1 2'h1
`define PIT_SEL_CH2 2'h2
`define PIT_SEL_CTRL 2'h3
`define PIT_NUM_CH 3

// ==========================================================================
// control word fields
`define PIT_CW_PICK_HI 7
`define PIT_CW_PICK_LO 6
`define PIT_CW_RW_HI 5
`define PIT_CW_RW_LO 4
`define PIT_PICK_READBACK 2'h3
`define PIT_RW_LATCH 2'h0
`define PIT_RW_LSB 2'h1
`define PIT_RW_MSB 2'h2
`define PIT_RW_BOTH 2'h3
`define PIT_RB_NO_COUNT 5
`define PIT_RB_NO_STATUS 4
`define PIT_RB_CH_BASE 1

// ==========================================================================
// reset values
`define PIT_CW_RESET 6'h00
`define PIT_BYTE_RESET 8'h00
`define PIT_COUNT_RESET 16'h0000

`endif

// ==== common/pit_pkg.sv ====
// types shared by the interval timer design
// assumes: nothing beyond the map header
// ==========================================================================
package pit_pkg;

  typedef enum logic {
    PIT_PH_LSB = 1'b0,
    PIT_PH_MSB = 1'b1
  } pit_phase_t;

  // bus pins after inversion to active high, one sampling stage
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [7:0] dat;
  } pit_bus_t;

  typedef struct packed {
    logic [5:0] cw;
    logic [15:0] ce;
    logic [15:0] snap;
    logic snap_held;
    logic [7:0] stat;
    logic stat_held;
    logic [7:0] hold_hi;
    logic [7:0] hold_lo;
    pit_phase_t wr_ph;
    pit_phase_t rd_ph;
    logic load_pend;
    logic null_cnt;
    logic out;
  } pit_chan_t;

  typedef struct packed {
    pit_bus_t s1;
    pit_bus_t s2;
    logic wr_prev;
    logic rd_prev;
    logic [7:0] wdat;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic [2:0] ck_s1;
    logic [2:0] ck_s2;
    logic [2:0] ck_prev;
    logic [2:0] gt_s1;
    logic [2:0] gt_s2;
    logic [7:0] dout;
    pit_chan_t [2:0] ch;
  } pit_state_t;

endpackage : pit_pkg

// ==== src/pit_top.sv ====
// three-channel interval timer: bus interface and per-channel count path
// assumes: all pins but rst are asynchronous to mclk and are sampled twice here;
// the bus strobes and counter clocks are slow against mclk (several
// mclk periods per phase), the data bus is stable while write is low
`include "pit_map.svh"

module pit_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] port_sel,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe,
  input wire logic [2:0] ctr_clk,
  input wire logic [2:0] ctr_gate,
  output logic [2:0] ctr_out
);

  // ========================================================================
  // helpers

  // down count by one; in decimal mode each nibble wraps 0 -> 9
  function automatic logic [15:0] pit_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (borrow) begin
          if (v[k*4 +: 4] == 4'h0) begin
            r[k*4 +: 4] = 4'h9;
          end else begin
            r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : pit_dec

  // byte that a read of this channel would put on the bus
  function automatic logic [7:0] pit_rd_byte(input pit_pkg::pit_chan_t c);
    logic [7:0] b;
    b = c.snap[7:0];
    if (c.stat_held) begin
      b = c.stat;
    end else begin
      case (c.cw[`PIT_CW_RW_HI-:2])
        `PIT_RW_MSB: b = c.snap[15:8];
        `PIT_RW_BOTH: b = (c.rd_ph == pit_pkg::PIT_PH_MSB) ? c.snap[15:8] : c.snap[7:0];
        default: b = c.snap[7:0];
      endcase
    end
    return b;
  endfunction : pit_rd_byte

  // a port select names a counter, not the control word
  function automatic logic pit_is_counter(input logic [1:0] s);
    return s != `PIT_SEL_CTRL;
  endfunction : pit_is_counter

  // ========================================================================
  // state

  pit_pkg::pit_state_t st_r;
  pit_pkg::pit_state_t st_nxt;

  logic wr_sel;
  logic rd_sel;
  logic wr_done;
  logic rd_done;
  logic cw_done;
  logic [1:0] pick;
  logic [1:0] rw_f;

  // both strobes qualified by device select
  assign wr_sel = st_r.s2.wr & st_r.s2.cs;
  assign rd_sel = st_r.s2.rd & st_r.s2.cs;
  // an access commits when its strobe is released
  assign wr_done = st_r.wr_prev & ~wr_sel;
  assign rd_done = st_r.rd_prev & ~rd_sel;
  // a control word commit outranks a read release landing in the same cycle,
  // so a latch set is never undone by a read that finishes alongside it
  assign cw_done = wr_done & (st_r.wsel == `PIT_SEL_CTRL);
  assign pick = st_r.wdat[`PIT_CW_PICK_HI:`PIT_CW_PICK_LO];
  assign rw_f = st_r.wdat[`PIT_CW_RW_HI:`PIT_CW_RW_LO];

  // ========================================================================
  // next state

  always_comb begin
    st_nxt = st_r;

    // two stages on every pin before any decision
    st_nxt.s1 = {~cs_n, ~rd_n, ~wr_n, port_sel, d_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.ck_s1 = ctr_clk;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_prev = st_r.ck_s2;
    st_nxt.gt_s1 = ctr_gate;
    st_nxt.gt_s2 = st_r.gt_s1;
    st_nxt.wr_prev = wr_sel;
    st_nxt.rd_prev = rd_sel;

    // keep the last address and data seen while the strobe was active,
    // so the commit on release never uses a settling bus
    if (wr_sel) begin
      st_nxt.wdat = st_r.s2.dat;
      st_nxt.wsel = st_r.s2.sel;
    end
    if (rd_sel) begin
      st_nxt.rsel = st_r.s2.sel;
    end

    for (int i = 0; i < `PIT_NUM_CH; i++) begin
      // each channel has its own copy of everything below

      // ---- counter clock: load pending count, else count under gate
      if (st_r.ck_s2[i] & ~st_r.ck_prev[i]) begin
        if (st_r.ch[i].load_pend) begin
          st_nxt.ch[i].ce = {st_r.ch[i].hold_hi, st_r.ch[i].hold_lo};
          st_nxt.ch[i].load_pend = 1'b0;
          st_nxt.ch[i].null_cnt = 1'b0;
        end else if (st_r.gt_s2[i]) begin
          st_nxt.ch[i].ce = pit_dec(st_r.ch[i].ce, st_r.ch[i].cw[0]);
          if (st_r.ch[i].ce == 16'h0001) begin
            st_nxt.ch[i].out = 1'b1;
          end
        end
      end

      // ---- control word and read-back command
      if (wr_done && st_r.wsel == `PIT_SEL_CTRL) begin
        if (pick == 2'(i)) begin
          if (rw_f == `PIT_RW_LATCH) begin
            // a second latch before the read is ignored
            st_nxt.ch[i].snap_held = 1'b1;
          end else begin
            st_nxt.ch[i].cw = st_r.wdat[5:0];
            st_nxt.ch[i].hold_hi = `PIT_BYTE_RESET;
            st_nxt.ch[i].hold_lo = `PIT_BYTE_RESET;
            st_nxt.ch[i].wr_ph = pit_pkg::PIT_PH_LSB;
            st_nxt.ch[i].rd_ph = pit_pkg::PIT_PH_LSB;
            st_nxt.ch[i].load_pend = 1'b0;
            st_nxt.ch[i].null_cnt = 1'b1;
            st_nxt.ch[i].out = 1'b0;
            st_nxt.ch[i].snap_held = 1'b0;
            st_nxt.ch[i].stat_held = 1'b0;
          end
        end else if (pick == `PIT_PICK_READBACK
                     && st_r.wdat[`PIT_RB_CH_BASE + i]) begin
          if (!st_r.wdat[`PIT_RB_NO_COUNT]) begin
            st_nxt.ch[i].snap_held = 1'b1;
          end
          if (!st_r.wdat[`PIT_RB_NO_STATUS] && !st_r.ch[i].stat_held) begin
            st_nxt.ch[i].stat = {st_r.ch[i].out, st_r.ch[i].null_cnt,
                                 st_r.ch[i].cw};
            st_nxt.ch[i].stat_held = 1'b1;
          end
        end
      end

      // ---- count bytes land in the holding register once a read/write format is programmed
      if (wr_done && st_r.wsel == 2'(i)) begin
        // mode bits are left alone by a count write
        st_nxt.ch[i].null_cnt = 1'b1;
        case (st_r.ch[i].cw[`PIT_CW_RW_HI-:2])
          `PIT_RW_LSB: begin
            st_nxt.ch[i].hold_lo = st_r.wdat;
            st_nxt.ch[i].load_pend = 1'b1;
          end
          `PIT_RW_MSB: begin
            st_nxt.ch[i].hold_hi = st_r.wdat;
            st_nxt.ch[i].load_pend = 1'b1;
          end
          `PIT_RW_BOTH: begin
            // the transfer waits for the second byte so both go together
            if (st_r.ch[i].wr_ph == pit_pkg::PIT_PH_LSB) begin
              st_nxt.ch[i].hold_lo = st_r.wdat;
              st_nxt.ch[i].wr_ph = pit_pkg::PIT_PH_MSB;
            end else begin
              st_nxt.ch[i].hold_hi = st_r.wdat;
              st_nxt.ch[i].wr_ph = pit_pkg::PIT_PH_LSB;
              st_nxt.ch[i].load_pend = 1'b1;
            end
          end
          default: begin
            // unprogrammed channel: count byte has no format, dropped
            st_nxt.ch[i].null_cnt = st_r.ch[i].null_cnt;
          end
        endcase
      end

      // ---- a finished read releases status first, then the count
      if (rd_done && !cw_done && st_r.rsel == 2'(i)) begin
        if (st_r.ch[i].stat_held) begin
          st_nxt.ch[i].stat_held = 1'b0;
        end else if (st_r.ch[i].cw[`PIT_CW_RW_HI-:2] == `PIT_RW_BOTH) begin
          if (st_r.ch[i].rd_ph == pit_pkg::PIT_PH_LSB) begin
            st_nxt.ch[i].rd_ph = pit_pkg::PIT_PH_MSB;
          end else begin
            st_nxt.ch[i].rd_ph = pit_pkg::PIT_PH_LSB;
            st_nxt.ch[i].snap_held = 1'b0;
          end
        end else begin
          st_nxt.ch[i].snap_held = 1'b0;
        end
      end

      // ---- snapshot follows the counter while not frozen
      if (!st_nxt.ch[i].snap_held) begin
        st_nxt.ch[i].snap = st_nxt.ch[i].ce;
      end
    end

    // ---- read data register: snapshot or status byte of the selected counter, zero on the control select
    case (st_r.s2.sel)
      `PIT_SEL_CH0: st_nxt.dout = pit_rd_byte(st_r.ch[0]);
      `PIT_SEL_CH1: st_nxt.dout = pit_rd_byte(st_r.ch[1]);
      `PIT_SEL_CH2: st_nxt.dout = pit_rd_byte(st_r.ch[2]);
      default: st_nxt.dout = `PIT_BYTE_RESET;
    endcase
  end

  // ========================================================================
  // registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // outputs

  // a read of the control address leaves the bus floating
  assign d_oe = rd_sel & pit_is_counter(st_r.s2.sel);
  assign d_out = st_r.dout;

  genvar g;
  generate
    for (g = 0; g < `PIT_NUM_CH; g++) begin : g_out
      assign ctr_out[g] = st_r.ch[g].out;
    end
  endgenerate

endmodule : pit_top

// ==== bench/pit_top_assertions.sv ====
// checker: bus and output timing of the timer top, seen at its ports
// assumes: bound to pit_top; bus pins idle while rst is high
module pit_top_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] port_sel,
  input wire logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic d_oe,
  input wire logic [2:0] ctr_clk,
  input wire logic [2:0] ctr_gate,
  input wire logic [2:0] ctr_out
);
  // ==========================================================
  // properties: pins pass two sync stages, so d_oe lags them by 2
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_cs_gate; cs_n [*3] |-> !d_oe; endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("bus driven while deselected");
  property p_oe_cause; d_oe |-> $past(!cs_n, 2) && $past(!rd_n, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven too early");
  property p_oe_follow;
    ($past(!cs_n, 2) && $past(!rd_n, 2) && $past(port_sel, 2) != 2'h3) |-> d_oe;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("read not driven");
  property p_ctrl_wo; $past(port_sel, 2) == 2'h3 |-> !d_oe; endproperty
  a_ctrl_wo: assert property (p_ctrl_wo) else $error("control port was read");
  property p_oe_release; $rose(rd_n) |-> ##2 !d_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus held after read");
  // six quiet cycles cover the sync and commit delays of clock and write
  property p_out_quiet; (wr_n && $stable(ctr_clk)) [*6] |=> $stable(ctr_out); endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output moved unprompted");
  property p_prog_clear;
    ($rose(wr_n) && !cs_n && port_sel == 2'h3 && d_in[7:4] == 4'h5) |-> ##5 !ctr_out[1];
  endproperty
  a_prog_clear: assert property (p_prog_clear) else $error("programming kept output");
  property p_rst_idle; @(posedge mclk) disable iff (1'b0) rst |=> !d_oe && ctr_out == 3'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset left outputs active");
  c_read: cover property ($rose(d_oe));
  c_term: cover property ($rose(ctr_out[1]));
  c_prog: cover property ($rose(wr_n) && !cs_n && port_sel == 2'h3);
endmodule : pit_top_assertions

bind pit_top pit_top_assertions chk_i (.mclk(mclk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .port_sel(port_sel), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
  .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out));

// ==== bench/pit_cpu_model.sv ====
// processor model on the timer's 8-bit peripheral bus
// assumes: one access at a time; signals change 5 ns after mclk rises
module pit_cpu_model (
  input wire logic mclk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] port_sel,
  output logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic d_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // bus cycles: strobes held 4 cycles, above the 1 and 3 minimums
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_sel = 2'h0;
    d_in = 8'hA5;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic sel_n);
    cs_n = sel_n;
    port_sel = a;
    d_in = d;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(1);
    cs_n = 1'b1;
    // released bus shows the inverse so a stale byte cannot pass
    d_in = ~d;
    cyc(3);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic sel_n, output logic [7:0] q,
    output logic oe);
    cs_n = sel_n;
    port_sel = a;
    rd_n = 1'b0;
    cyc(4);
    q = d_out;
    oe = d_oe;
    rd_n = 1'b1;
    cyc(1);
    cs_n = 1'b1;
    cyc(3);
  endtask : rd
endmodule : pit_cpu_model

// ==== bench/interval_timer_bus_count_path_bench.sv ====
// self-checking bench of the timer top with a processor bus model
// assumes: 10 MHz mclk; counter clocks made here, 4 mclk per phase
module interval_timer_bus_count_path_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, cs_n, rd_n, wr_n, d_oe;
  logic [1:0] port_sel;
  logic [7:0] d_in, d_out;
  logic [2:0] ctr_clk, ctr_gate, ctr_out;
  int n_fail = 0, checks = 0, cycles = 0;
  pit_top uut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel(port_sel), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
    .ctr_clk(ctr_clk), .ctr_gate(ctr_gate), .ctr_out(ctr_out));
  pit_cpu_model cpu (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_sel(port_sel), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  // ==========================================================
  // clock, timeout and reporting
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    logic oe;
    cpu.rd(a, 1'b0, q, oe);
    chk({7'h00, oe}, 8'h01, "bus driven on read");
    chk(q, exp, what);
  endtask : rdc
  task automatic tick(input int ch, input int n);
    repeat (n) begin
      ctr_clk[ch] = 1'b1;
      cpu.cyc(4);
      ctr_clk[ch] = 1'b0;
      cpu.cyc(4);
    end
  endtask : tick
  // ==========================================================
  // scenarios
  task automatic s_two_byte();
    cpu.wr(2'h3, 8'h30, 1'b0);
    cpu.wr(2'h0, 8'h34, 1'b0);
    cpu.wr(2'h0, 8'h12, 1'b0);
    rdc(2'h0, 8'h00, "lsb before load");
    rdc(2'h0, 8'h00, "msb before load");
    tick(0, 1);
    rdc(2'h0, 8'h34, "loaded lsb");
    rdc(2'h0, 8'h12, "loaded msb");
    tick(0, 2);
    ctr_gate[0] = 1'b0;
    cpu.cyc(4);
    tick(0, 1);
    ctr_gate[0] = 1'b1;
    cpu.wr(2'h3, 8'h00, 1'b0);
    tick(0, 1);
    rdc(2'h0, 8'h32, "frozen lsb");
    rdc(2'h0, 8'h12, "frozen msb");
    rdc(2'h0, 8'h31, "live lsb");
    rdc(2'h0, 8'h12, "live msb");
    $display("done two_byte");
  endtask : s_two_byte
  task automatic s_one_byte();
    cpu.wr(2'h3, 8'h70, 1'b0);
    cpu.wr(2'h1, 8'hAA, 1'b0);
    cpu.wr(2'h1, 8'hBB, 1'b0);
    cpu.wr(2'h3, 8'h50, 1'b0);
    cpu.wr(2'h1, 8'h07, 1'b0);
    tick(1, 7);
    chk({5'h00, ctr_out}, 8'h00, "out before zero");
    tick(1, 1);
    chk({5'h00, ctr_out}, 8'h02, "out at zero");
    cpu.wr(2'h3, 8'h50, 1'b0);
    chk({5'h00, ctr_out}, 8'h00, "out after reprogram");
    $display("done one_byte");
  endtask : s_one_byte
  task automatic s_status();
    cpu.wr(2'h3, 8'h96, 1'b0);
    cpu.wr(2'h3, 8'hE8, 1'b0);
    rdc(2'h2, 8'h56, "status new");
    cpu.wr(2'h2, 8'h09, 1'b0);
    cpu.wr(2'h3, 8'hE8, 1'b0);
    rdc(2'h2, 8'h56, "status pending");
    tick(2, 1);
    cpu.wr(2'h3, 8'hE8, 1'b0);
    rdc(2'h2, 8'h16, "status loaded");
    rdc(2'h2, 8'h09, "count after status");
    $display("done status");
  endtask : s_status
  task automatic s_deselect();
    logic [7:0] q;
    logic oe;
    // if taken, this word would reprogram channel 2 and its status would change
    cpu.wr(2'h3, 8'hB0, 1'b1);
    cpu.wr(2'h3, 8'hE8, 1'b0);
    rdc(2'h2, 8'h16, "status kept");
    cpu.rd(2'h2, 1'b1, q, oe);
    chk({7'h00, oe}, 8'h00, "deselected read");
    cpu.rd(2'h3, 1'b0, q, oe);
    chk({7'h00, oe}, 8'h00, "control port read");
    $display("done deselect");
  endtask : s_deselect
  // decimal counting, high-byte-only format and the read-back count latch
  task automatic s_bcd_msb();
    cpu.wr(2'h3, 8'h21, 1'b0);
    cpu.wr(2'h0, 8'h10, 1'b0);
    tick(0, 1);
    cpu.wr(2'h3, 8'hD2, 1'b0);
    tick(0, 1);
    rdc(2'h0, 8'h10, "read-back latched msb");
    rdc(2'h0, 8'h09, "decimal count msb");
    $display("done bcd_msb");
  endtask : s_bcd_msb
  initial begin
    rst = 1'b1;
    ctr_clk = 3'h0;
    ctr_gate = 3'h7;
    repeat (16) @(posedge mclk);
    #5;
    rst = 1'b0;
    s_two_byte();
    s_one_byte();
    s_status();
    s_deselect();
    s_bcd_msb();
    end_of_test();
  end
endmodule : interval_timer_bus_count_path_bench
